// File: verilog/ccgcr_defines.vh
// Register map constants of the clock generator configuration bank
// Assumes an 8-bit data, 10-bit address register access port
`ifndef CCGCR_DEFINES_VH
`define CCGCR_DEFINES_VH

`define CCGCR_AW 10
`define CCGCR_ADDR_PORT_CFG 10'h000
`define CCGCR_ADDR_UNUSED1 10'h001
`define CCGCR_ADDR_RSVD2 10'h002
`define CCGCR_ADDR_DEV_CODE 10'h003
`define CCGCR_ADDR_READBACK 10'h004
`define CCGCR_ADDR_VER_LO 10'h005
`define CCGCR_ADDR_VER_HI 10'h006
`define CCGCR_ADDR_PUMP 10'h010
`define CCGCR_ADDR_REFDIV_LO 10'h011
`define CCGCR_ADDR_REFDIV_HI 10'h012
`define CCGCR_ADDR_SWALLOW 10'h013

`define CCGCR_RST_PORT_CFG 8'h00
`define CCGCR_RST_READBACK 8'h00
`define CCGCR_RST_VER_LO 8'h00
`define CCGCR_RST_VER_HI 8'h00
`define CCGCR_RST_PUMP 8'h7D
`define CCGCR_RST_REFDIV_LO 8'h01
`define CCGCR_RST_REFDIV_HI 6'h00
`define CCGCR_RST_SWALLOW 6'h00

// Serial port config fields: mirrored pairs
`define CCGCR_PC_SOFT_RST_LO 2
`define CCGCR_PC_SOFT_RST_HI 5
`define CCGCR_PC_KEEP_MASK 8'hC3
`define CCGCR_READBACK_BIT 0
`define CCGCR_REFDIV_HI_W 6
`define CCGCR_SWALLOW_W 6

`endif

// File: verilog/ccgcr_bank.v
// Low-address configuration register bank of a PLL clock generator
// Assumes a serial-port engine issuing one-cycle wr_en/rd_en strobes
`include "ccgcr_defines.vh"

module ccgcr_bank #(
  parameter [7:0] DEVICE_CODE = 8'h5A // Arbitrary neutral value
) (
  input wire clock,
  input wire rst_n,
  input wire [`CCGCR_AW-1:0] addr,
  input wire [7:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  input wire update,
  output reg [7:0] rd_data_q,
  output reg read_active_q,
  output reg soft_reset_q,
  output reg [7:0] pump_setup_q,
  output reg [13:0] ref_divider_q,
  output reg [5:0] swallow_count_q,
  output reg [15:0] eeprom_version_q
);

  // ==========================================================
  // Buffer registers
  reg [7:0] port_cfg_q;
  reg [7:0] buf_pump_q;
  reg [7:0] buf_ref_lo_q;
  reg [5:0] buf_ref_hi_q;
  reg [5:0] buf_swallow_q;
  reg [7:0] buf_ver_lo_q;
  reg [7:0] buf_ver_hi_q;
  reg [7:0] rd_d;
  wire soft_req;

  assign soft_req = wr_en && (addr == `CCGCR_ADDR_PORT_CFG) &&
    (wr_data[`CCGCR_PC_SOFT_RST_LO] || wr_data[`CCGCR_PC_SOFT_RST_HI]);

  // ==========================================================
  // Write decode
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      port_cfg_q <= `CCGCR_RST_PORT_CFG;
      read_active_q <= 1'b0;
      buf_pump_q <= `CCGCR_RST_PUMP;
      buf_ref_lo_q <= `CCGCR_RST_REFDIV_LO;
      buf_ref_hi_q <= `CCGCR_RST_REFDIV_HI;
      buf_swallow_q <= `CCGCR_RST_SWALLOW;
      buf_ver_lo_q <= `CCGCR_RST_VER_LO;
      buf_ver_hi_q <= `CCGCR_RST_VER_HI;
      soft_reset_q <= 1'b0;
    end else if (soft_reset_q) begin
      port_cfg_q <= `CCGCR_RST_PORT_CFG;
      read_active_q <= 1'b0;
      buf_pump_q <= `CCGCR_RST_PUMP;
      buf_ref_lo_q <= `CCGCR_RST_REFDIV_LO;
      buf_ref_hi_q <= `CCGCR_RST_REFDIV_HI;
      buf_swallow_q <= `CCGCR_RST_SWALLOW;
      buf_ver_lo_q <= `CCGCR_RST_VER_LO;
      buf_ver_hi_q <= `CCGCR_RST_VER_HI;
      soft_reset_q <= 1'b0;
    end else begin
      soft_reset_q <= soft_req;
      if (wr_en) begin
        case (addr)
          `CCGCR_ADDR_PORT_CFG: begin
            port_cfg_q <= wr_data & `CCGCR_PC_KEEP_MASK;
          end
          `CCGCR_ADDR_READBACK: begin
            read_active_q <= wr_data[`CCGCR_READBACK_BIT];
          end
          `CCGCR_ADDR_VER_LO: begin
            buf_ver_lo_q <= wr_data;
          end
          `CCGCR_ADDR_VER_HI: begin
            buf_ver_hi_q <= wr_data;
          end
          `CCGCR_ADDR_PUMP: begin
            buf_pump_q <= wr_data;
          end
          `CCGCR_ADDR_REFDIV_LO: begin
            buf_ref_lo_q <= wr_data;
          end
          `CCGCR_ADDR_REFDIV_HI: begin
            buf_ref_hi_q <= wr_data[`CCGCR_REFDIV_HI_W-1:0];
          end
          `CCGCR_ADDR_SWALLOW: begin
            buf_swallow_q <= wr_data[`CCGCR_SWALLOW_W-1:0];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Active registers, loaded by update
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pump_setup_q <= `CCGCR_RST_PUMP;
      ref_divider_q <= {`CCGCR_RST_REFDIV_HI, `CCGCR_RST_REFDIV_LO};
      swallow_count_q <= `CCGCR_RST_SWALLOW;
      eeprom_version_q <= {`CCGCR_RST_VER_HI, `CCGCR_RST_VER_LO};
    end else if (soft_reset_q) begin
      pump_setup_q <= `CCGCR_RST_PUMP;
      ref_divider_q <= {`CCGCR_RST_REFDIV_HI, `CCGCR_RST_REFDIV_LO};
      swallow_count_q <= `CCGCR_RST_SWALLOW;
      eeprom_version_q <= {`CCGCR_RST_VER_HI, `CCGCR_RST_VER_LO};
    end else if (update) begin
      pump_setup_q <= buf_pump_q;
      ref_divider_q <= {buf_ref_hi_q, buf_ref_lo_q};
      swallow_count_q <= buf_swallow_q;
      eeprom_version_q <= {buf_ver_hi_q, buf_ver_lo_q};
    end
  end

  // ==========================================================
  // Read mux
  always @* begin
    rd_d = 8'h00;
    case (addr)
      `CCGCR_ADDR_PORT_CFG: rd_d = port_cfg_q;
      `CCGCR_ADDR_DEV_CODE: rd_d = DEVICE_CODE;
      `CCGCR_ADDR_READBACK: rd_d = {7'h00, read_active_q};
      `CCGCR_ADDR_VER_LO:
        rd_d = read_active_q ? eeprom_version_q[7:0] : buf_ver_lo_q;
      `CCGCR_ADDR_VER_HI:
        rd_d = read_active_q ? eeprom_version_q[15:8] : buf_ver_hi_q;
      `CCGCR_ADDR_PUMP:
        rd_d = read_active_q ? pump_setup_q : buf_pump_q;
      `CCGCR_ADDR_REFDIV_LO:
        rd_d = read_active_q ? ref_divider_q[7:0] : buf_ref_lo_q;
      `CCGCR_ADDR_REFDIV_HI:
        rd_d = {2'h0, read_active_q ? ref_divider_q[13:8] : buf_ref_hi_q};
      `CCGCR_ADDR_SWALLOW:
        rd_d = {2'h0, read_active_q ? swallow_count_q : buf_swallow_q};
      default: rd_d = 8'h00;
    endcase
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= 8'h00;
    end else if (rd_en) begin
      rd_data_q <= rd_d;
    end
  end

endmodule

// File: verification/ccgcr_checker.sv
// Checker of the configuration register bank ports
// Assumes one clock domain with async active-low reset
module ccgcr_checker(
  input wire clock,
  input wire rst_n,
  input wire [9:0] addr,
  input wire [7:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  input wire update,
  input wire [7:0] rd_data_q,
  input wire read_active_q,
  input wire soft_reset_q,
  input wire [13:0] ref_divider_q,
  input wire [15:0] eeprom_version_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire wa = wr_en && !soft_reset_q;
  chk_soft_pulse: assert property (
    wa && addr == 0 && (wr_data[2] || wr_data[5]) |=>
    soft_reset_q ##1 !soft_reset_q) else $error("soft reset pulse wrong");
  chk_soft_dflt: assert property (
    soft_reset_q |=> ref_divider_q == 14'h0001 && !read_active_q &&
    eeprom_version_q == 16'h0000) else $error("soft reset defaults wrong");
  chk_rb_bit: assert property (
    wa && addr == 10'h004 |=> read_active_q == $past(wr_data[0]))
    else $error("readback select wrong");
  chk_div_high: assert property (
    wa && addr == 10'h012 ##1 update |=>
    ref_divider_q[13:8] == $past(wr_data[5:0], 2))
    else $error("divider high bits wrong");
  chk_div_top: assert property (
    rd_en && addr == 10'h012 |=> rd_data_q[7:6] == 2'h0)
    else $error("divider unused bits read back");
  chk_ver_low: assert property (
    wa && addr == 10'h005 ##1 update |=>
    eeprom_version_q[7:0] == $past(wr_data, 2))
    else $error("version low wrong");
  chk_unmapped: assert property (
    rd_en && (addr > 10'h013 || addr == 10'h001 || addr == 10'h002 ||
    (addr > 10'h006 && addr < 10'h010)) |=> rd_data_q == 8'h00)
    else $error("unused address holds data");
endmodule
bind ccgcr_bank ccgcr_checker chk(.clock, .rst_n, .addr, .wr_data, .wr_en,
  .rd_en, .update, .rd_data_q, .read_active_q, .soft_reset_q,
  .ref_divider_q, .eeprom_version_q);

// File: verification/ccgcr_host.sv
// Host model: serial-port engine strobes toward the bank
// Assumes the bank samples on rising clock edges
module ccgcr_host(
  input wire clock,
  output logic [9:0] addr,
  output logic [7:0] wr_data,
  output logic wr_en,
  output logic rd_en,
  output logic update
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {addr, wr_data, wr_en, rd_en, update} = 21'h0;
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge clock) {addr, wr_data, wr_en} = {a, d, 1'b1};
    @(negedge clock) {addr, wr_data, wr_en} = {~a, ~d, 1'b0};
  endtask
  task automatic rd(input logic [9:0] a);
    @(negedge clock) {addr, rd_en} = {a, 1'b1};
    @(negedge clock) {addr, rd_en} = {~a, 1'b0};
  endtask
  task automatic upd;
    @(negedge clock) update = 1'b1;
    @(negedge clock) update = 1'b0;
  endtask
endmodule

// File: verification/tb_ccgcr_bank.sv
// Testbench of the configuration register bank
// Assumes the host model drives all strobes at falling edges
module tb_ccgcr_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, rst_n = 1'b0, wr_en, rd_en, update;
  logic read_active_q, soft_reset_q;
  logic [9:0] addr;
  logic [7:0] wr_data, rd_data_q, pump_setup_q;
  logic [13:0] ref_divider_q;
  logic [5:0] swallow_count_q;
  logic [15:0] eeprom_version_q;
  int n_errors = 0, total_checks = 0;
  initial forever #2.5 clock = ~clock;
  ccgcr_host h(.clock, .addr, .wr_data, .wr_en, .rd_en, .update);
  ccgcr_bank dut(.clock, .rst_n, .addr, .wr_data, .wr_en, .rd_en, .update,
    .rd_data_q, .read_active_q, .soft_reset_q, .pump_setup_q, .ref_divider_q,
    .swallow_count_q, .eeprom_version_q);
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [9:0] a, input logic [7:0] e);
    h.rd(a);
    cmp({8'h00, rd_data_q}, {8'h00, e});
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    static logic [9:0] ign[6] = '{10'h001, 10'h002, 10'h007, 10'h00F,
      10'h014, 10'h3FF};
    repeat (16) @(negedge clock);
    rst_n = 1'b1;
    cmp(pump_setup_q, 16'h007D);
    cmp(ref_divider_q, 16'h0001);
    cmp(swallow_count_q, 16'h0000);
    h.wr(10'h013, 8'hFF);
    h.wr(10'h010, 8'hA5);
    h.upd;
    cmp(swallow_count_q, 16'h003F);
    cmp(pump_setup_q, 16'h00A5);
    rdc(10'h013, 8'h3F);
    h.wr(10'h011, 8'h34);
    h.wr(10'h012, 8'hFF);
    h.upd;
    cmp(ref_divider_q, 16'h3F34);
    rdc(10'h012, 8'h3F);
    h.wr(10'h005, 8'hEF);
    h.wr(10'h006, 8'hBE);
    h.upd;
    cmp(eeprom_version_q, 16'hBEEF);
    rdc(10'h005, 8'hEF);
    h.wr(10'h004, 8'h01);
    h.wr(10'h011, 8'h56);
    rdc(10'h011, 8'h34);
    h.wr(10'h004, 8'h00);
    rdc(10'h011, 8'h56);
    $display("divider, version and readback tests done");
    foreach (ign[i]) begin
      h.wr(ign[i], 8'hFF);
      rdc(ign[i], 8'h00);
    end
    rdc(10'h003, 8'h5A);
    h.upd;
    cmp(ref_divider_q, 16'h3F56);
    $display("ignored address test done");
    foreach (ign[i]) if (i < 2) begin
      h.wr(10'h011, 8'h09);
      h.upd;
      cmp(ref_divider_q[7:0], 16'h0009);
      h.wr(10'h000, i ? 8'h20 : 8'h04);
      repeat (2) @(negedge clock);
      cmp(ref_divider_q, 16'h0001);
      rdc(10'h000, 8'h00);
      cmp(pump_setup_q, 16'h007D);
      cmp(soft_reset_q, 16'h0000);
    end
    $display("soft reset test done");
    end_of_test;
  end
endmodule
